// *** occ_clock_control.sv ***
// Oscillator stop, CPU clock source and PLL select/lock control.
// Assumes software writes arrive as one-cycle strobes with data;
// the watchdog overflow and stabilization level are synchronous inputs.
module occ_clock_control #(
  parameter int SEL_W = occ_pkg::SEL_W
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_opt_osc_ctrl_en,
  input wire logic i_osc_ctrl_wr,
  input wire logic i_osc_stop_wdata,
  input wire logic i_stab_active,
  input wire logic i_wdt_overflow,
  input wire logic i_pll_ctrl_wr,
  input wire logic i_pll_run_wdata,
  input wire logic i_pll_sel_wdata,
  input wire logic i_lock_sel_wr,
  input wire logic [SEL_W-1:0] i_lock_sel_wdata,
  input wire logic i_clkout_wr,
  input wire logic i_clkout_en_wdata,
  output logic o_int_osc_stop_bit,
  output logic o_int_osc_run,
  output logic [7:0] o_cpu_clock_source_status_reg,
  output logic o_pll_run_bit,
  output logic o_pll_clock_select_bit,
  output logic o_pll_lock_flag,
  output logic [SEL_W-1:0] o_lockup_time_select_reg,
  output logic o_clock_output_enable_bit,
  output logic o_clock_output_active
);
  import occ_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  logic stop_reg;
  logic src_flag_reg;
  logic pll_run_reg;
  logic pll_sel_reg;
  logic lock_reg;
  logic [SEL_W-1:0] lock_sel_reg;
  logic clkout_en_reg;
  occ_pll_state_t state_reg;
  occ_pll_state_t state_next;
  logic timer_done;

  // Writes reach the oscillator register only when the option byte allows
  wire logic osc_wr_ok = i_osc_ctrl_wr && i_opt_osc_ctrl_en;
  wire logic wdt_in_stab = i_wdt_overflow && i_stab_active;
  wire logic run_next = i_pll_ctrl_wr ? i_pll_run_wdata : pll_run_reg;
  wire logic pll_start = run_next && !pll_run_reg;
  wire logic pll_stop = !run_next && pll_run_reg;
  // Select forced low unless locked, and with the run bit
  wire logic sel_next = i_pll_ctrl_wr ?
      (i_pll_sel_wdata && lock_reg && run_next) :
      (pll_sel_reg && run_next);
  wire logic [CNT_W-1:0] lock_len =
      (lock_sel_reg == 2'h0) ? CNT_W'(LOCK_CYC_0) :
      (lock_sel_reg == 2'h1) ? CNT_W'(LOCK_CYC_1) :
      (lock_sel_reg == 2'h2) ? CNT_W'(LOCK_CYC_2) : CNT_W'(LOCK_CYC_3);
  // Lockup select is frozen during lockup to keep the count coherent
  wire logic lock_sel_ok = i_lock_sel_wr && (state_reg != OCC_WAIT);
  // Output enable may only rise while the PLL runs
  wire logic clkout_next = i_clkout_wr ?
      (i_clkout_en_wdata && pll_run_reg) : (clkout_en_reg && run_next);

  //////////////////////////////////////////////////////////////////////////
  // Lock flag follows this sequence, never the analog lock signal
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      OCC_STOP: begin
        if (pll_start) begin
          state_next = OCC_WAIT;
        end
      end
      OCC_WAIT: begin
        if (pll_stop) begin
          state_next = OCC_STOP;
        end else if (timer_done) begin
          state_next = OCC_LOCKED;
        end
      end
      OCC_LOCKED: begin
        if (pll_stop) begin
          state_next = OCC_STOP;
        end
      end
    endcase
  end

  occ_lock_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_start(pll_start),
    .i_abort(pll_stop),
    .i_length(lock_len),
    .o_done(timer_done)
  );

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stop_reg <= 1'b0;
      src_flag_reg <= 1'b0;
      pll_run_reg <= 1'b0;
      pll_sel_reg <= 1'b0;
      lock_reg <= 1'b0;
      lock_sel_reg <= LOCK_SEL_RST;
      clkout_en_reg <= 1'b0;
      state_reg <= OCC_STOP;
    end else if (i_ce) begin
      if (osc_wr_ok) begin
        stop_reg <= i_osc_stop_wdata;
      end
      // Sticky until reset: CPU now runs on the internal oscillator
      if (wdt_in_stab) begin
        src_flag_reg <= 1'b1;
      end
      pll_run_reg <= run_next;
      pll_sel_reg <= sel_next;
      state_reg <= state_next;
      lock_reg <= (state_next == OCC_LOCKED);
      if (lock_sel_ok) begin
        lock_sel_reg <= i_lock_sel_wdata;
      end
      clkout_en_reg <= clkout_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered copies keep every output straight from a flip-flop
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_osc_stop_bit <= 1'b0;
      o_int_osc_run <= 1'b1;
      o_cpu_clock_source_status_reg <= SRC_STATUS_RST;
      o_pll_run_bit <= 1'b0;
      o_pll_clock_select_bit <= 1'b0;
      o_pll_lock_flag <= 1'b0;
      o_lockup_time_select_reg <= LOCK_SEL_RST;
      o_clock_output_enable_bit <= 1'b0;
      o_clock_output_active <= 1'b0;
    end else if (i_ce) begin
      o_int_osc_stop_bit <= stop_reg;
      // Oscillator cannot stop while the CPU depends on it
      o_int_osc_run <= !stop_reg || src_flag_reg;
      o_cpu_clock_source_status_reg <= src_flag_reg ? SRC_STATUS_WDT : SRC_STATUS_RST;
      o_pll_run_bit <= pll_run_reg;
      o_pll_clock_select_bit <= pll_sel_reg;
      o_pll_lock_flag <= lock_reg;
      o_lockup_time_select_reg <= lock_sel_reg;
      o_clock_output_enable_bit <= clkout_en_reg;
      o_clock_output_active <= clkout_en_reg && pll_run_reg;
    end
  end
endmodule

// *** occ_pkg.sv ***
// Constants for the oscillator and PLL clock control block.
// Assumes a single 50 MHz reference clock and plain-port software access.
// Operation
// - Oscillator control writes need option-byte enable
// - Oscillator runs while flag set; stop bit kept
// - Watchdog overflow in stabilization sets flag, reads 01H
// - Clearing PLL run bit clears clock select
// - Clock select accepts 1 only when locked
// - Lock flag is not instantaneous lock state
// - Watchdog overflow in stabilization selects internal oscillator
package occ_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LOCK_MIN_US = 800;
  // Least lockup count at the reference rate, cycles per us rounded down
  localparam int unsigned LOCK_MIN_CYC = (LOCK_MIN_US * (CLK_HZ / 1_000_000));
  localparam int SEL_W = 2;
  // Lockup cycles per selection code; code 0 is below the minimum wait
  localparam int unsigned LOCK_CYC_0 = 32'h0000_4E20;
  localparam int unsigned LOCK_CYC_1 = 32'h0000_9C40;
  localparam int unsigned LOCK_CYC_2 = 32'h0001_3880;
  localparam int unsigned LOCK_CYC_3 = 32'h0002_7100;
  localparam logic [7:0] SRC_STATUS_RST = 8'h00;
  localparam logic [7:0] SRC_STATUS_WDT = 8'h01;
  localparam logic [SEL_W-1:0] LOCK_SEL_RST = 2'h3;
  localparam int CNT_W = 20;
  typedef enum logic [2:0] {
    OCC_STOP = 3'b001,
    OCC_WAIT = 3'b010,
    OCC_LOCKED = 3'b100
  } occ_pll_state_t;
endpackage

// *** occ_lock_timer.sv ***
// Lockup timer: counts the selected lockup period once started.
// Assumes start is a one-cycle pulse and abort clears it at once.
module occ_lock_timer #(
  parameter int CNT_W = 20
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [CNT_W-1:0] i_length,
  output logic o_done
);
  import occ_pkg::*;
  logic [CNT_W-1:0] cnt_reg;
  logic run_reg;
  wire logic last = run_reg && (cnt_reg == '0);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= last && !i_abort;
      if (i_abort) begin
        run_reg <= 1'b0;
      end else if (i_start) begin
        run_reg <= 1'b1;
        cnt_reg <= i_length - CNT_W'(1);
      end else if (last) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
    end
  end
endmodule

// *** occ_clock_control_monitor.sv ***
// Port checker for the oscillator and PLL clock control block.
// Bound to every occ_clock_control instance; sees its ports only.
module occ_ctl_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_opt_osc_ctrl_en,
  input wire logic i_stab_active,
  input wire logic i_wdt_overflow,
  input wire logic o_int_osc_stop_bit,
  input wire logic o_int_osc_run,
  input wire logic [7:0] o_cpu_clock_source_status_reg,
  input wire logic o_pll_run_bit,
  input wire logic o_pll_clock_select_bit,
  input wire logic o_pll_lock_flag,
  input wire logic o_clock_output_active
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  sel_run_a: assert property (o_pll_clock_select_bit |-> o_pll_run_bit)
    else $error("select set while run bit clear");
  sel_lock_a: assert property ($rose(o_pll_clock_select_bit) |-> $past(o_pll_lock_flag))
    else $error("select set before lock");
  // Lockup is thousands of cycles, so eight is a safe floor
  lock_slow_a: assert property ($rose(o_pll_run_bit) |-> !o_pll_lock_flag [*8])
    else $error("lock flag followed run at once");
  lock_clear_a: assert property ($fell(o_pll_run_bit) |-> ##[0:2] !o_pll_lock_flag)
    else $error("lock flag kept after stop");
  src_set_a: assert property (i_ce && i_wdt_overflow && i_stab_active
    |-> ##[1:3] o_cpu_clock_source_status_reg == 8'h01) else $error("source flag not set");
  src_hold_a: assert property (o_cpu_clock_source_status_reg[0] |=>
    o_cpu_clock_source_status_reg == 8'h01) else $error("source flag lost");
  osc_keep_a: assert property (o_cpu_clock_source_status_reg[0] |-> o_int_osc_run)
    else $error("oscillator stopped under cpu");
  opt_gate_a: assert property (!i_opt_osc_ctrl_en [*3] |-> $stable(o_int_osc_stop_bit))
    else $error("stop bit changed while writes disabled");
  clkout_run_a: assert property (o_clock_output_active |-> o_pll_run_bit)
    else $error("clock output without pll");
  lock_c: cover property ($rose(o_pll_lock_flag));
  sel_c: cover property ($rose(o_pll_clock_select_bit));
  src_c: cover property ($rose(o_cpu_clock_source_status_reg[0]));
endmodule
bind occ_clock_control occ_ctl_monitor u_occ_ctl_monitor (.i_ref_clk, .i_rst_n, .i_ce,
  .i_opt_osc_ctrl_en, .i_stab_active, .i_wdt_overflow, .o_int_osc_stop_bit, .o_int_osc_run,
  .o_cpu_clock_source_status_reg, .o_pll_run_bit, .o_pll_clock_select_bit, .o_pll_lock_flag,
  .o_clock_output_active);

// *** tb_occ_clock_control.sv ***
// Self-checking bench for occ_clock_control.
// Drives plain ports at the rising edge; lockup code 1 keeps the run short.
module tb_occ_clock_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_rst_n, i_ce, i_opt_osc_ctrl_en, i_osc_ctrl_wr, i_osc_stop_wdata;
  logic i_stab_active, i_wdt_overflow, i_pll_ctrl_wr, i_pll_run_wdata, i_pll_sel_wdata;
  logic i_lock_sel_wr, i_clkout_wr, i_clkout_en_wdata, o_int_osc_stop_bit, o_int_osc_run;
  logic o_pll_run_bit, o_pll_clock_select_bit, o_pll_lock_flag, o_clock_output_enable_bit;
  logic o_clock_output_active;
  logic [1:0] i_lock_sel_wdata, o_lockup_time_select_reg;
  logic [7:0] o_cpu_clock_source_status_reg;
  int miscompares = 0;
  int check_count = 0;
  wire logic [7:0] st = {o_int_osc_stop_bit, o_int_osc_run, o_pll_run_bit, o_pll_lock_flag,
    o_pll_clock_select_bit, o_clock_output_enable_bit, o_lockup_time_select_reg};
  occ_clock_control u_occ_clock_control (.i_ref_clk, .i_rst_n, .i_ce, .i_opt_osc_ctrl_en,
    .i_osc_ctrl_wr, .i_osc_stop_wdata, .i_stab_active, .i_wdt_overflow, .i_pll_ctrl_wr,
    .i_pll_run_wdata, .i_pll_sel_wdata, .i_lock_sel_wr, .i_lock_sel_wdata, .i_clkout_wr,
    .i_clkout_en_wdata, .o_int_osc_stop_bit, .o_int_osc_run, .o_cpu_clock_source_status_reg,
    .o_pll_run_bit, .o_pll_clock_select_bit, .o_pll_lock_flag, .o_lockup_time_select_reg,
    .o_clock_output_enable_bit, .o_clock_output_active);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Kind 0 oscillator, 1 pll run/select, 2 lockup code, 3 clock output
  task automatic wr(input int k, input logic [1:0] d);
    @(posedge i_ref_clk);
    {i_osc_stop_wdata, i_pll_run_wdata, i_pll_sel_wdata, i_lock_sel_wdata} <= {d[0], d, d};
    i_clkout_en_wdata <= d[0];
    {i_osc_ctrl_wr, i_pll_ctrl_wr, i_lock_sel_wr, i_clkout_wr} <= 4'h8 >> k;
    @(posedge i_ref_clk);
    {i_osc_ctrl_wr, i_pll_ctrl_wr, i_lock_sel_wr, i_clkout_wr} <= 4'h0;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_osc();
    chk(st, 8'h43);
    chk(o_cpu_clock_source_status_reg, 8'h00);
    wr(0, 2'h1);
    chk(st, 8'h43);
    @(posedge i_ref_clk);
    i_opt_osc_ctrl_en <= 1'b1;
    wr(0, 2'h1);
    chk(st, 8'h83);
    wr(0, 2'h0);
    // Clock enable low must freeze every register, writes included
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    wr(0, 2'h1);
    chk(st, 8'h43);
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(st, 8'h43);
  endtask
  task automatic t_pll();
    // Lockup code is chosen before the PLL starts, never during lockup
    wr(2, 2'h1);
    chk(st, 8'h41);
    wr(1, 2'h3);
    chk(st, 8'h61);
    // Pin setup is outside this block; the enable comes only after it
    wr(3, 2'h1);
    chk(st, 8'h65);
    repeat (30000) @(negedge i_ref_clk);
    chk(st, 8'h65);
    for (int i = 0; i < 11000 && o_pll_lock_flag !== 1'b1; i++) @(negedge i_ref_clk);
    chk(st, 8'h75);
    wr(1, 2'h3);
    chk(st, 8'h7D);
    chk({7'h0, o_clock_output_active}, 8'h01);
    wr(3, 2'h0);
    wr(1, 2'h0);
    chk(st, 8'h41);
  endtask
  task automatic t_wdt();
    // Stop is written before the CPU moves to the oscillator
    wr(0, 2'h1);
    chk(st, 8'h81);
    @(posedge i_ref_clk);
    {i_stab_active, i_wdt_overflow} <= 2'h3;
    @(posedge i_ref_clk);
    i_wdt_overflow <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(o_cpu_clock_source_status_reg, 8'h01);
    chk(st, 8'hC1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    {i_rst_n, i_opt_osc_ctrl_en, i_osc_ctrl_wr, i_osc_stop_wdata, i_stab_active} = 5'h0;
    {i_wdt_overflow, i_pll_ctrl_wr, i_pll_run_wdata, i_pll_sel_wdata, i_lock_sel_wr} = 5'h0;
    {i_clkout_wr, i_clkout_en_wdata, i_lock_sel_wdata} = 4'h0;
    i_ce = 1'b1;
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(negedge i_ref_clk);
    t_osc();
    t_pll();
    t_wdt();
    end_of_test();
  end
  // Tests need about 40100 cycles
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    miscompares++;
    end_of_test();
  end
endmodule
